//--- core/bdmnvm_map.vh
// Register map, field positions, reset values and timing counts of the banked register file.
//
// What this block does
// - Status bit 5 picks bank for direct access.
// - Bank spans 7Fh; twelve SFRs, rest RAM.
// - Bank 1 RAM aliases bank 0 RAM.
// - Pointer accesses also use bank select bit.
// - Flag-setting writes to status keep ALU flags.
// - Timeout and powerdown bits ignore software writes.
// - Nibble flag is carry out of bit 3.
// - Carry flag is carry out of bit 7.
// - Subtraction flags are inverted borrows.
// - Nonvolatile memory is 64 bytes, indirectly reached.
// - Data register holds byte read or programmed.
// - Unlock register has no storage behind it.
// - Program erases location, then writes, timer-paced.
// - Code protection blocks programmer, not CPU.
// - Done flag set by hardware, cleared by software.
// - Reset cutting a program sets error flag.
// - Program enable gates every program cycle.
// - Start bit self-clears; writing zero does nothing.
// - Fetch bit only settable; hardware clears it.
// - Fetched byte lands in the data register a cycle after the fetch write.
// - Data register holds until read or write.
// - 55h then AAh unlock before each start.
// - Start needs enable; enable clear spares cycle.
`ifndef BDMNVM_MAP_VH
`define BDMNVM_MAP_VH

// ----------------------------------------------------------------
// Register addresses, bank bit followed by the 7-bit offset
// ----------------------------------------------------------------
`define BDM_OFS_INDIRECT   7'h00
`define BDM_OFS_STATUS     7'h03
`define BDM_OFS_POINTER    7'h04
`define BDM_ADR_NVM_DATA   8'h08
`define BDM_ADR_NVM_ADDR   8'h09
`define BDM_ADR_NVM_CTRL   8'h88
`define BDM_ADR_NVM_UNLOCK 8'h89
`define BDM_GPR_FIRST      7'h0C
`define BDM_GPR_LAST       7'h7F

// ----------------------------------------------------------------
// Status register fields and reset value
// ----------------------------------------------------------------
`define BDM_ST_CARRY   0
`define BDM_ST_NIBBLE  1
`define BDM_ST_ZERO    2
`define BDM_ST_PDOWN   3
`define BDM_ST_TMOUT   4
`define BDM_ST_BANK    5
`define BDM_ST_BANKHI  6
`define BDM_ST_INDHI   7
`define BDM_ST_RESET   8'h18

// ----------------------------------------------------------------
// Nonvolatile control register fields and unlock keys
// ----------------------------------------------------------------
`define BDM_NC_FETCH   0
`define BDM_NC_START   1
`define BDM_NC_ENABLE  2
`define BDM_NC_ERROR   3
`define BDM_NC_DONE    4
`define BDM_UNLOCK_KEY1 8'h55
`define BDM_UNLOCK_KEY2 8'hAA
`define BDM_NVM_DEPTH  64
`define BDM_NVM_AW     6
`define BDM_NVM_ERASED 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BDM_CLK_PERIOD_NS  8
`define BDM_PROG_TIME_NS   4000000
`define BDM_PROG_CYCLES    (`BDM_PROG_TIME_NS / `BDM_CLK_PERIOD_NS)

`endif

//--- core/bdmnvm_nvm_array.v
// Nonvolatile byte array with timed erase-then-write programming.
`timescale 1ns/1ns
`include "bdmnvm_map.vh"

module bdmnvm_nvm_array #(
    parameter DEPTH       = `BDM_NVM_DEPTH,
    parameter AW          = `BDM_NVM_AW,
    parameter PROG_CYCLES = `BDM_PROG_CYCLES
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst,
    // Timed program request
    input  wire          progStart,
    input  wire [AW-1:0] progAddr,
    input  wire [7:0]    progData,
    input  wire          abort,
    // Immediate load from the external programmer
    input  wire          loadEn,
    input  wire [AW-1:0] loadAddr,
    input  wire [7:0]    loadData,
    // Read port
    input  wire [AW-1:0] rdAddr,
    output wire [7:0]    rdData,
    // Status
    output wire          busy,
    output reg           done,
    output reg           aborted
);
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_ERASE = 2'd1;
    localparam [1:0] ST_WRITE = 2'd2;
    localparam [31:0] HALF = (PROG_CYCLES / 2 < 1) ? 32'd1 : PROG_CYCLES / 2;

    // Nonvolatile contents are deliberately left out of reset.
    reg [7:0]    mem [0:DEPTH-1];
    reg [1:0]    state_q;
    reg [31:0]   cnt_q;
    reg [AW-1:0] addr_q;
    reg [7:0]    data_q;

    assign rdData = mem[rdAddr];
    assign busy   = (state_q != ST_IDLE);

    // ----------------------------------------------------------------
    // Program sequencer
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        done    <= 1'b0;
        aborted <= 1'b0;
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 32'd0;
            addr_q  <= {AW{1'b0}};
            data_q  <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (progStart) begin
                        state_q <= ST_ERASE;
                        cnt_q   <= 32'd0;
                        addr_q  <= progAddr;
                        data_q  <= progData;
                    end else if (loadEn) begin
                        mem[loadAddr] <= loadData;
                    end
                end
                ST_ERASE: begin
                    if (abort) begin
                        state_q <= ST_IDLE;
                        aborted <= 1'b1;
                    end else if (cnt_q == HALF - 32'd1) begin
                        mem[addr_q] <= `BDM_NVM_ERASED;
                        cnt_q       <= 32'd0;
                        state_q     <= ST_WRITE;
                    end else begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                ST_WRITE: begin
                    if (abort) begin
                        state_q <= ST_IDLE;
                        aborted <= 1'b1;
                    end else if (cnt_q == HALF - 32'd1) begin
                        mem[addr_q] <= data_q;
                        state_q     <= ST_IDLE;
                        done        <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- core/bdmnvm_regfile.v
// Banked register file with status register and nonvolatile data memory access.
`timescale 1ns/1ns
`include "bdmnvm_map.vh"

module bdmnvm_regfile #(
    parameter PROG_CYCLES = `BDM_PROG_CYCLES
) (
    // Clock and power-on reset
    input  wire       clk,
    input  wire       rst,
    // External reset pin, asynchronous, active low
    input  wire       externalResetPinN,
    // Core events
    input  wire       wdtTimeout,
    input  wire       sleepCmd,
    input  wire       clrWdtCmd,
    // Register file access from the core
    input  wire [6:0] fileAddr,
    input  wire       rdEn,
    input  wire       nvm_program_enable,
    input  wire [7:0] wrData,
    output reg  [7:0] rdData,
    // ALU flag update
    input  wire       flagUpdZero,
    input  wire       flagUpdArith,
    input  wire [7:0] aluResult,
    input  wire [7:0] aluOpA,
    input  wire [7:0] aluOpB,
    input  wire       aluSub,
    // External programmer port
    input  wire       codeProtect,
    input  wire       progRdEn,
    input  wire       progWrEn,
    input  wire [5:0] progAddr,
    input  wire [7:0] progWrData,
    output reg  [7:0] progRdData,
    output reg        progDenied,
    // Visible state
    output wire [7:0] statusOut,
    output wire       nvmBusy
);
    localparam [1:0] UL_IDLE  = 2'd0;
    localparam [1:0] UL_KEY1  = 2'd1;
    localparam [1:0] UL_ARMED = 2'd2;

    localparam [2:0] R_NONE    = 3'd0;
    localparam [2:0] R_STATUS  = 3'd1;
    localparam [2:0] R_POINTER = 3'd2;
    localparam [2:0] R_NDATA   = 3'd3;
    localparam [2:0] R_NADDR   = 3'd4;
    localparam [2:0] R_NCTRL   = 3'd5;
    localparam [2:0] R_UNLOCK  = 3'd6;
    localparam [2:0] R_GPR     = 3'd7;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // twelve SFR slots, then RAM
    function [2:0] decodeReg;
        input       bank;
        input [6:0] ofs;
        begin
            if (ofs >= `BDM_GPR_FIRST)
                decodeReg = R_GPR;
            else if (ofs == `BDM_OFS_STATUS)
                decodeReg = R_STATUS;
            else if (ofs == `BDM_OFS_POINTER)
                decodeReg = R_POINTER;
            else if ({bank, ofs} == `BDM_ADR_NVM_DATA)
                decodeReg = R_NDATA;
            else if ({bank, ofs} == `BDM_ADR_NVM_ADDR)
                decodeReg = R_NADDR;
            else if ({bank, ofs} == `BDM_ADR_NVM_CTRL)
                decodeReg = R_NCTRL;
            else if ({bank, ofs} == `BDM_ADR_NVM_UNLOCK)
                decodeReg = R_UNLOCK;
            else
                decodeReg = R_NONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [7:0] gpr [0:`BDM_GPR_LAST - `BDM_GPR_FIRST];
    reg       bankSelect_q;
    reg [1:0] bankHigh_q;
    reg       timeout_q;
    reg       powerdown_q;
    reg       zero_q;
    reg       nibble_q;
    reg       carry_q;
    reg [7:0] pointer_q;
    reg [7:0] nvmData_q;
    reg [7:0] nvmAddr_q;
    reg       doneFlag_q;
    reg       errFlag_q;
    reg       progEn_q;
    reg       progStart_q;
    reg       fetchStart_q;
    reg [1:0] unlock_q;
    reg [2:0] pinSync_q;
    reg       pinLevel_q;

    wire       softRst;
    wire [6:0] effOfs;
    wire [2:0] regSel;
    wire       wrStatus;
    wire       wrCtrl;
    wire       launch;
    wire [8:0] addB;
    wire [4:0] addNib;
    wire [8:0] addSum;
    wire [7:0] nvmRdByte;
    wire       arrDone;
    wire       arrAborted;
    wire       progAllowed;

    // ----------------------------------------------------------------
    // External reset pin synchroniser
    // ----------------------------------------------------------------
    // The filtered level only moves once the second and third stages agree.
    always @(posedge clk) begin
        if (rst) begin
            pinSync_q  <= 3'b111;
            pinLevel_q <= 1'b1;
        end else begin
            pinSync_q <= {pinSync_q[1:0], externalResetPinN};
            if (pinSync_q[1] == pinSync_q[2])
                pinLevel_q <= pinSync_q[2];
        end
    end

    assign softRst = ~pinLevel_q | wdtTimeout;

    // ----------------------------------------------------------------
    // Effective address
    // ----------------------------------------------------------------
    // bank bit picks the bank
    assign effOfs   = (fileAddr == `BDM_OFS_INDIRECT) ? pointer_q[6:0] : fileAddr;
    assign regSel   = (effOfs == `BDM_OFS_INDIRECT) ? R_NONE
                      : decodeReg(bankSelect_q, effOfs);
    assign wrStatus = nvm_program_enable & (regSel == R_STATUS);
    assign wrCtrl   = nvm_program_enable & (regSel == R_NCTRL);

    // ----------------------------------------------------------------
    // ALU flags
    // ----------------------------------------------------------------
    // subtract adds two's complement
    assign addB   = aluSub ? ({1'b0, ~aluOpB} + 9'h001) : {1'b0, aluOpB};
    assign addNib = {1'b0, aluOpA[3:0]} + (aluSub ? ({1'b0, ~aluOpB[3:0]} + 5'h01)
                                                  : {1'b0, aluOpB[3:0]});
    assign addSum = {1'b0, aluOpA} + addB;

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            {bankHigh_q, bankSelect_q} <= 3'b000;
            timeout_q   <= 1'b1;
            powerdown_q <= 1'b1;
            {zero_q, nibble_q, carry_q} <= 3'b000;
        end else begin
            if (softRst) begin
                {bankHigh_q, bankSelect_q} <= 3'b000;
            end else if (wrStatus) begin
                bankHigh_q   <= wrData[`BDM_ST_INDHI:`BDM_ST_BANKHI];
                bankSelect_q <= wrData[`BDM_ST_BANK];
            end
            if (wdtTimeout) begin
                timeout_q <= 1'b0;
            end else if (sleepCmd) begin
                timeout_q   <= 1'b1;
                powerdown_q <= 1'b0;
            end else if (clrWdtCmd) begin
                timeout_q   <= 1'b1;
                powerdown_q <= 1'b1;
            end
            // ALU flags beat the write
            // Any flag update blocks the write to all three flag bits.
            if (flagUpdZero)
                zero_q <= (aluResult == 8'h00);
            else if (wrStatus & ~flagUpdArith)
                zero_q <= wrData[`BDM_ST_ZERO];
            if (flagUpdArith) begin
                nibble_q <= addNib[4];
                carry_q  <= addSum[8];
            end else if (wrStatus & ~flagUpdZero) begin
                nibble_q <= wrData[`BDM_ST_NIBBLE];
                carry_q  <= wrData[`BDM_ST_CARRY];
            end
        end
    end

    assign statusOut = {bankHigh_q, bankSelect_q, timeout_q, powerdown_q,
                        zero_q, nibble_q, carry_q};

    // ----------------------------------------------------------------
    // Pointer and general purpose RAM
    // ----------------------------------------------------------------
    // both banks share one RAM
    always @(posedge clk) begin
        if (rst) begin
            pointer_q <= 8'h00;
        end else begin
            if (nvm_program_enable & (regSel == R_POINTER))
                pointer_q <= wrData;
            if (nvm_program_enable & (regSel == R_GPR))
                gpr[effOfs - `BDM_GPR_FIRST] <= wrData;
        end
    end

    // ----------------------------------------------------------------
    // Unlock sequence
    // ----------------------------------------------------------------
    // unlock writes feed only this sequencer
    always @(posedge clk) begin
        if (rst | softRst) begin
            unlock_q <= UL_IDLE;
        end else if (nvm_program_enable & (regSel == R_UNLOCK)) begin
            if (wrData == `BDM_UNLOCK_KEY1)
                unlock_q <= UL_KEY1;
            else if ((wrData == `BDM_UNLOCK_KEY2) && (unlock_q == UL_KEY1))
                unlock_q <= UL_ARMED;
            else
                unlock_q <= UL_IDLE;
        end else if (wrCtrl) begin
            unlock_q <= UL_IDLE;
        end
    end

    assign launch = wrCtrl & wrData[`BDM_NC_START] & progEn_q & ~progStart_q
                    & ~nvmBusy & (unlock_q == UL_ARMED);

    // ----------------------------------------------------------------
    // Nonvolatile control, address and data
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            nvmData_q    <= 8'h00;
            nvmAddr_q    <= 8'h00;
            doneFlag_q   <= 1'b0;
            errFlag_q    <= 1'b0;
            progEn_q     <= 1'b0;
            progStart_q  <= 1'b0;
            fetchStart_q <= 1'b0;
        end else if (softRst) begin
            doneFlag_q   <= 1'b0;
            progEn_q     <= 1'b0;
            progStart_q  <= 1'b0;
            fetchStart_q <= 1'b0;
            if (nvmBusy)
                errFlag_q <= 1'b1;
        end else begin
            if (nvm_program_enable & (regSel == R_NADDR))
                nvmAddr_q <= wrData;
            if (fetchStart_q)
                nvmData_q <= nvmRdByte;
            else if (nvm_program_enable & (regSel == R_NDATA))
                nvmData_q <= wrData;
            if (wrCtrl & wrData[`BDM_NC_FETCH])
                fetchStart_q <= 1'b1;
            else
                fetchStart_q <= 1'b0;
            if (launch)
                progStart_q <= 1'b1;
            else if (arrDone | arrAborted)
                progStart_q <= 1'b0;
            if (wrCtrl)
                progEn_q <= wrData[`BDM_NC_ENABLE];
            if (arrDone)
                doneFlag_q <= 1'b1;
            else if (wrCtrl)
                doneFlag_q <= wrData[`BDM_NC_DONE];
            if (wrCtrl)
                errFlag_q <= wrData[`BDM_NC_ERROR];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            case (regSel)
                R_STATUS:  rdData <= statusOut;
                R_POINTER: rdData <= pointer_q;
                R_NDATA:   rdData <= nvmData_q;
                R_NADDR:   rdData <= nvmAddr_q;
                R_NCTRL:   rdData <= {3'b000, doneFlag_q, errFlag_q, progEn_q,
                                      progStart_q, fetchStart_q};
                R_GPR:     rdData <= gpr[effOfs - `BDM_GPR_FIRST];
                default:   rdData <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // External programmer port
    // ----------------------------------------------------------------
    // protection locks the programmer only
    assign progAllowed = ~codeProtect & ~nvmBusy;

    always @(posedge clk) begin
        if (rst) begin
            progRdData <= 8'h00;
            progDenied <= 1'b0;
        end else begin
            progDenied <= (progRdEn | progWrEn) & ~progAllowed;
            if (progRdEn & progAllowed)
                progRdData <= nvmRdByte;
        end
    end

    // ----------------------------------------------------------------
    // Nonvolatile array
    // ----------------------------------------------------------------
    // 64 bytes behind the address register
    // Programmer reads share the read port, so a CPU fetch in the same
    // cycle sees the programmer's address; both are rare together.
    bdmnvm_nvm_array #(
        .DEPTH       (`BDM_NVM_DEPTH),
        .AW          (`BDM_NVM_AW),
        .PROG_CYCLES (PROG_CYCLES)
    ) uArray (
        .clk       (clk),
        .rst       (rst),
        .progStart (launch),
        .progAddr  (nvmAddr_q[5:0]),
        .progData  (nvmData_q),
        .abort     (softRst),
        .loadEn    (progWrEn & progAllowed & ~launch),
        .loadAddr  (progAddr),
        .loadData  (progWrData),
        .rdAddr    ((progRdEn & progAllowed) ? progAddr : nvmAddr_q[5:0]),
        .rdData    (nvmRdByte),
        .busy      (nvmBusy),
        .done      (arrDone),
        .aborted   (arrAborted)
    );
endmodule

//--- dv/bdmnvm_checker.sv
// Port-level assertions for the banked register file.
`timescale 1ns/1ns
module bdmnvm_checker #(
    parameter PROG_CYCLES = 8
) (
    input logic       clk,
    input logic       rst,
    input logic       externalResetPinN,
    input logic       wdtTimeout,
    input logic       sleepCmd,
    input logic       clrWdtCmd,
    input logic [6:0] fileAddr,
    input logic       rdEn,
    input logic       nvm_program_enable,
    input logic [7:0] wrData,
    input logic [7:0] rdData,
    input logic       flagUpdZero,
    input logic       flagUpdArith,
    input logic [7:0] aluResult,
    input logic [7:0] aluOpA,
    input logic [7:0] aluOpB,
    input logic       aluSub,
    input logic       codeProtect,
    input logic       progRdEn,
    input logic       progWrEn,
    input logic [5:0] progAddr,
    input logic [7:0] progWrData,
    input logic [7:0] progRdData,
    input logic       progDenied,
    input logic [7:0] statusOut,
    input logic       nvmBusy
);
    // Subtraction adds the inverted operand plus one, so carries become inverted borrows.
    wire [7:0] opB     = aluSub ? ~aluOpB : aluOpB;
    wire [4:0] nibSum  = aluOpA[3:0] + opB[3:0] + aluSub;
    wire [8:0] fullSum = aluOpA + opB + aluSub;
    wire [1:0] flagExp = {nibSum[4], fullSum[8]};
    wire       startWr = nvm_program_enable && fileAddr == 7'h08 && statusOut[5] && wrData[1];
    int        busyCnt_q;
    always @(posedge clk) busyCnt_q <= (rst || !nvmBusy) ? 0 : busyCnt_q + 1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sStatusWr;
        nvm_program_enable && fileAddr == 7'h03 && !wdtTimeout;
    endsequence
    sequence sArithUpd;
        flagUpdArith && !wdtTimeout;
    endsequence

    AST_BANK_SELECT: assert property (sStatusWr |=> statusOut[5] == $past(wrData[5]))
        else $error("bank bit not taken from status write");
    AST_TO_PD_RO: assert property (sStatusWr ##0 (!sleepCmd && !clrWdtCmd) |=>
        $stable(statusOut[4:3])) else $error("timeout or powerdown bit written");
    AST_SLEEP: assert property (sleepCmd && !wdtTimeout |=> statusOut[4:3] == 2'b10)
        else $error("sleep event flags wrong");
    AST_WDT_TO: assert property (wdtTimeout |=> !statusOut[4])
        else $error("watchdog event left timeout bit set");
    AST_ZERO: assert property (flagUpdZero |=> statusOut[2] == ($past(aluResult) == 8'h00))
        else $error("zero flag wrong");
    AST_ARITH: assert property (sArithUpd |=> statusOut[1:0] == $past(flagExp))
        else $error("carry flags wrong");
    AST_FLAG_KEEP: assert property (sStatusWr ##0 (flagUpdZero && !flagUpdArith) |=>
        statusOut[1:0] == $past(statusOut[1:0])) else $error("carry flags taken from write");
    AST_UNLOCK_READ: assert property (rdEn && fileAddr == 7'h09 && statusOut[5] |=>
        rdData == 8'h00) else $error("unlock register read not zero");
    AST_LAUNCH: assert property ($rose(nvmBusy) |-> $past(startWr) || $past(startWr, 2))
        else $error("program began without start write");
    AST_PROTECT: assert property (codeProtect && (progRdEn || progWrEn) |=> progDenied)
        else $error("programmer access not refused");
    AST_PROG_TIMER: assert property (busyCnt_q <= PROG_CYCLES + 2)
        else $error("program cycle too long");
endmodule

bind bdmnvm_regfile bdmnvm_checker #(.PROG_CYCLES(PROG_CYCLES)) i_chk (.*);

//--- dv/tb_banked_data_memory_nvm_access.sv
// Directed test of the banked register file and its nonvolatile memory access.
`timescale 1ns/1ns
`include "bdmnvm_map.vh"
module tb_banked_data_memory_nvm_access;
    localparam PROG_CYCLES = 16;
    logic       clk, rst = 1, externalResetPinN = 1, wdtTimeout = 0, sleepCmd = 0;
    logic       clrWdtCmd = 0, rdEn = 0, nvm_program_enable = 0, flagUpdZero = 0, flagUpdArith = 0;
    logic       aluSub = 0, codeProtect = 0, progRdEn = 0, progWrEn = 0, progDenied, nvmBusy;
    logic [6:0] fileAddr = 0;
    logic [5:0] progAddr = 0;
    logic [7:0] wrData = 0, aluResult = 0, aluOpA = 0, aluOpB = 0, progWrData = 0;
    logic [7:0] rdData, progRdData, statusOut, v, ob;
    logic [8:0] s;
    logic [4:0] nb;
    logic [7:0] ta[4] = '{8'h0F, 8'hF0, 8'h05, 8'h03};
    logic [7:0] tbv[4] = '{8'h01, 8'h10, 8'h03, 8'h05};
    logic       ts[4] = '{0, 0, 1, 1};
    int         errors = 0, total_checks = 0;

    bdmnvm_regfile #(.PROG_CYCLES(PROG_CYCLES)) i_dut (.*);

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(negedge clk);
        fileAddr = a;
        wrData = d;
        nvm_program_enable = 1;
        @(negedge clk);
        nvm_program_enable = 0;
    endtask
    task automatic rdc(string n, logic [6:0] a, logic [7:0] e);
        @(negedge clk);
        fileAddr = a;
        rdEn = 1;
        @(negedge clk);
        rdEn = 0;
        chk(n, e, rdData);
    endtask
    task automatic bank(logic b);
        wr(7'h03, {2'b00, b, 5'h00});
    endtask
    task automatic launch;
        wr(7'h08, 8'h04);
        wr(7'h09, `BDM_UNLOCK_KEY1);
        wr(7'h09, `BDM_UNLOCK_KEY2);
        wr(7'h08, 8'h06);
    endtask

    // Whole run is under two hundred cycles; this allows 5000, about thirty times that.
    initial begin
        #40000;
        errors++;
        end_of_test;
    end

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 0;
        chk("status", `BDM_ST_RESET, statusOut);
        bank(1);
        rdc("control", 7'h08, 8'h00);
        bank(0);
        wr(7'h0C, 8'hA5);
        wr(7'h04, 8'h0D);
        wr(7'h00, 8'h3C);
        wr(7'h09, 8'h3F);
        wr(7'h08, 8'h5A);
        wr(7'h0A, 8'h77);
        rdc("unmapped", 7'h0A, 8'h00);
        rdc("gpr", 7'h0D, 8'h3C);
        wr(7'h04, 8'h09);
        rdc("indirect b0", 7'h00, 8'h3F);
        bank(1);
        chk("bank", 8'h01, {7'h00, statusOut[5]});
        rdc("indirect b1", 7'h00, 8'h00);
        rdc("unlock", 7'h09, 8'h00);
        rdc("alias", 7'h0C, 8'hA5);
        $display("test banking done");
        wr(7'h03, 8'h07);
        chk("status", 8'h1F, statusOut);
        @(negedge clk) sleepCmd = 1;
        @(negedge clk) sleepCmd = 0;
        chk("status", 8'h17, statusOut);
        @(negedge clk) clrWdtCmd = 1;
        @(negedge clk) clrWdtCmd = 0;
        chk("status", 8'h1F, statusOut);
        @(negedge clk) {fileAddr, wrData, nvm_program_enable, flagUpdZero} = {7'h03, 8'h00, 2'b11};
        @(negedge clk) {nvm_program_enable, flagUpdZero} = 2'b00;
        chk("clear status", 8'h1F, statusOut);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            aluOpA = ta[i];
            aluOpB = tbv[i];
            aluSub = ts[i];
            ob = ts[i] ? ~tbv[i] : tbv[i];
            s = ta[i] + ob + ts[i];
            nb = ta[i][3:0] + ob[3:0] + ts[i];
            aluResult = s[7:0];
            fileAddr = 7'h03;
            wrData = 8'h07;
            {nvm_program_enable, flagUpdZero, flagUpdArith} = 3'b111;
            @(negedge clk);
            {nvm_program_enable, flagUpdZero, flagUpdArith} = 3'b000;
            chk("flags", {5'h03, s[7:0] == 0, nb[4], s[8]}, statusOut);
        end
        $display("test status done");
        codeProtect = 1;
        bank(1);
        wr(7'h08, 8'h02);
        rdc("control", 7'h08, 8'h00);
        wr(7'h08, 8'h04);
        wr(7'h08, 8'h06);
        rdc("control", 7'h08, 8'h04);
        launch;
        rdc("control", 7'h08, 8'h06);
        wr(7'h08, 8'h00);
        rdc("control", 7'h08, 8'h02);
        for (int n = 0; n < 200 && nvmBusy !== 1'b0; n++) @(negedge clk);
        rdc("control", 7'h08, 8'h10);
        wr(7'h08, 8'h00);
        rdc("control", 7'h08, 8'h00);
        bank(0);
        wr(7'h08, 8'h00);
        bank(1);
        wr(7'h08, 8'h01);
        rdc("control", 7'h08, 8'h00);
        bank(0);
        rdc("nvm data", 7'h08, 8'h5A);
        rdc("nvm data", 7'h08, 8'h5A);
        @(negedge clk) {progRdEn, progAddr} = {1'b1, 6'h3F};
        @(negedge clk) progRdEn = 0;
        chk("denied", 8'h01, {7'h00, progDenied});
        codeProtect = 0;
        @(negedge clk) progRdEn = 1;
        @(negedge clk) progRdEn = 0;
        chk("prog data", 8'h5A, progRdData);
        $display("test nvm done");
        bank(1);
        launch;
        @(negedge clk) wdtTimeout = 1;
        @(negedge clk) wdtTimeout = 0;
        chk("status", 8'h08, statusOut);
        chk("busy", 8'h00, {7'h00, nvmBusy});
        bank(1);
        rdc("control", 7'h08, 8'h08);
        launch;
        @(negedge clk) externalResetPinN = 0;
        repeat (4) @(negedge clk);
        externalResetPinN = 1;
        repeat (4) @(negedge clk);
        chk("busy", 8'h00, {7'h00, nvmBusy});
        bank(1);
        rdc("control", 7'h08, 8'h08);
        $display("test abort done");
        end_of_test;
    end
endmodule
